// file: src/dacsm_top.sv
// digital front end: serial audio in, mode select, soft mute, mute indicator
// assumes master clock, frame clock and pins are asynchronous to clk_sys
// and the serial bit clock is a clock of its own
//
// What this block does
// - reset low clears all state and holds low-power output high
// - single 16-50 kHz, double 50-100 kHz, quad 100-200 kHz
// - frame clock level decides whether bits are left or right
// - left-then-right pairs leave together; a right word with no held left is dropped
// - samples are two's complement msb first, shifted on the bit clock
// - format comes from mode byte in control mode, pins in hardware mode
// - mute active ramps down over 1152/2304/4608 frame clocks
// - mute release ramps up over 1152/2304/4608 frame clocks
// - mute indicator goes active only after ramp-down completes
// - mute indicator releases at once when mute input returns high
// - indicator low in init, reset, full mute, power-down, bad clock ratio
// - interface select 0 is hardware mode, 1 is control port mode
// - hardware mode pins pick format, de-emphasis and speed
// - in control mode a falling chip select enters spi mode
// - spi mode holds until reset or power-down
// - i2c uses shared pins as address bits; spi uses second as data in
// - spi control clock shifts data in and data out
// - format bits: 00 left, 01 i2s, 10 right 16, 11 right 24
// - single speed de-emphasis: 32k, 44.1k, 48k or off
// - top two bits high: third bit 1 double, 0 quad speed
`timescale 1ns/1ps
module dacsm_top #(
    parameter int RAMP_SINGLE = dacsm_pkg::RAMP_SINGLE,
    parameter int RAMP_DOUBLE = dacsm_pkg::RAMP_DOUBLE,
    parameter int RAMP_QUAD = dacsm_pkg::RAMP_QUAD
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic audioBitClock,
    input wire logic audioFrameClock,
    input wire logic audioSerialIn,
    input wire logic masterClock,
    input wire logic softMuteN,
    input wire logic interfaceSelect,
    input wire logic modePinE,
    input wire logic modePinD,
    input wire logic modePinC,
    input wire logic modePinB,
    input wire logic modePinAIn,
    output logic modePinAOut,
    output logic modePinAOe,
    input wire logic [4:0] ctrlModeBits,
    input wire logic ctrlPowerDown,
    input wire logic ctrlDataOutBit,
    output logic [dacsm_pkg::SAMPLE_W-1:0] sampleLeft,
    output logic [dacsm_pkg::SAMPLE_W-1:0] sampleRight,
    output logic sampleStrobe,
    output logic [dacsm_pkg::RAMP_W-1:0] gainNum,
    output logic [dacsm_pkg::RAMP_W-1:0] gainDen,
    output logic [1:0] speedMode,
    output logic [1:0] audioFormat,
    output logic [1:0] deemphSelect,
    output logic lowPower,
    output logic ratioFault,
    output logic spiModeActive,
    output logic [1:0] chipAddrBits,
    output logic [7:0] spiShiftData,
    output logic muteIndicatorOut
);
    localparam logic [12:0] LEN_S = 13'(RAMP_SINGLE);
    localparam logic [12:0] LEN_D = 13'(RAMP_DOUBLE);
    localparam logic [12:0] LEN_Q = 13'(RAMP_QUAD);

    // serial receiver on the bit clock domain
    logic [dacsm_pkg::SAMPLE_W-1:0] rxLeft, rxRight;
    logic rxToggle;
    logic [1:0] format_r;

    dacsm_serial_rx u_rx (
        .audioBitClock(audioBitClock),
        .rst_n(rst_n),
        .fmtSys(format_r),
        .audioFrameClock(audioFrameClock),
        .audioSerialIn(audioSerialIn),
        .pairLeft(rxLeft),
        .pairRight(rxRight),
        .pairToggle(rxToggle)
    );

    // every asynchronous input and the pair toggle pass three flops
    logic [dacsm_pkg::SYNC_W-1:0] syncQ;

    dacsm_pin_sync #(.W(dacsm_pkg::SYNC_W)) u_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d({masterClock, audioFrameClock, softMuteN, interfaceSelect, modePinE,
            modePinD, modePinC, modePinB, modePinAIn, rxToggle, 1'b0}),
        .q(syncQ)
    );

    wire mclkS = syncQ[10];
    wire frameS = syncQ[9];
    wire muteNS = syncQ[8];
    wire ctrlMode = syncQ[7];
    wire pinES = syncQ[6];
    wire pinDS = syncQ[5];
    wire pinCS = syncQ[4];
    wire pinBS = syncQ[3];
    wire pinAS = syncQ[2];
    wire toggleS = syncQ[1];

    // tolerant ratio check; sampling phase moves a count by one edge
    function automatic logic ratioAllowed(input logic [10:0] cnt, input logic [1:0] sh);
        logic [10:0] bases [4];
        logic [10:0] tgt;
        logic ok;
        bases[0] = dacsm_pkg::RATIO_A;
        bases[1] = dacsm_pkg::RATIO_B;
        bases[2] = dacsm_pkg::RATIO_C;
        bases[3] = dacsm_pkg::RATIO_D;
        ok = 1'b0;
        for (int i = 0; i < 4; i++) begin
            tgt = bases[i] >> sh;
            if (cnt + dacsm_pkg::RATIO_TOL >= tgt && cnt <= tgt + dacsm_pkg::RATIO_TOL) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction : ratioAllowed

    // edge detectors on the synchronised levels
    logic mclkPrev_r, framePrev_r, togglePrev_r, csPrev_r, cclkPrev_r;
    wire mclkRise = mclkS & ~mclkPrev_r;
    wire frameRise = frameS & ~framePrev_r;
    wire pairArrived = toggleS ^ togglePrev_r;

    // mode source: control byte or pins; pin b is ignored in control mode
    wire [4:0] pinBits = {pinES, pinDS, pinCS, pinBS, pinAS};
    wire [4:0] modeBits = ctrlMode ? ctrlModeBits : pinBits;
    wire mHi = modeBits[dacsm_pkg::MODE_HI_BIT];
    wire mMid = modeBits[dacsm_pkg::MODE_MID_BIT];
    wire mDq = modeBits[dacsm_pkg::MODE_DQ_BIT];
    // hi=1 with mid=0 is undefined and falls back to single speed
    wire [1:0] speedNxt = (mHi && mMid) ? (mDq ? 2'(dacsm_pkg::SPEED_DOUBLE)
        : 2'(dacsm_pkg::SPEED_QUAD)) : 2'(dacsm_pkg::SPEED_SINGLE);
    wire [1:0] formatNxt = modeBits[1:0];
    wire [1:0] deemphNxt = !mHi ? modeBits[3:2] : dacsm_pkg::DEEMPH_OFF;
    wire powerDown = ctrlMode & ctrlPowerDown;
    wire [12:0] rampLen = (speedNxt == 2'(dacsm_pkg::SPEED_QUAD)) ? LEN_Q
        : (speedNxt == 2'(dacsm_pkg::SPEED_DOUBLE)) ? LEN_D : LEN_S;

    // registered mode outputs
    logic [1:0] speed_r, deemph_r;
    logic lowPower_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            speed_r <= 2'(dacsm_pkg::SPEED_SINGLE);
            format_r <= dacsm_pkg::FMT_LEFT_JUST;
            deemph_r <= dacsm_pkg::DEEMPH_OFF;
            lowPower_r <= 1'b1;
        end else begin
            speed_r <= speedNxt;
            format_r <= formatNxt;
            deemph_r <= deemphNxt;
            lowPower_r <= powerDown;
        end
    end

    // master clock count per frame period; the first period after reset is
    // partial, so it only arms the check
    logic [10:0] mclkCount_r;
    logic armed_r, ratioOk_r;
    wire ratioOkNxt = frameRise ? armed_r && ratioAllowed(mclkCount_r, speedNxt) : ratioOk_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || powerDown) begin
            mclkCount_r <= '0;
            armed_r <= 1'b0;
            ratioOk_r <= 1'b0;
        end else if (frameRise) begin
            mclkCount_r <= mclkRise ? 11'h001 : 11'h000;
            armed_r <= 1'b1;
            ratioOk_r <= ratioOkNxt;
        end else if (mclkRise && mclkCount_r != 11'h7ff) begin
            mclkCount_r <= mclkCount_r + 11'h001;
        end
    end

    // soft mute ramp, stepped once per frame clock rising edge
    dacsm_pkg::dacsm_state_type state_r, stateNxt;
    logic [12:0] gain_r, gainNxt;
    wire muteReq = ~muteNS;

    always_comb begin
        stateNxt = state_r;
        gainNxt = gain_r;
        case (state_r)
            dacsm_pkg::ST_PLAY: begin
                gainNxt = rampLen;
                if (muteReq) begin
                    stateNxt = dacsm_pkg::ST_RAMP_DOWN;
                end
            end
            dacsm_pkg::ST_RAMP_DOWN: begin
                if (!muteReq) begin
                    stateNxt = dacsm_pkg::ST_RAMP_UP;
                end else if (frameRise) begin
                    if (gain_r <= 13'h0001) begin
                        gainNxt = '0;
                        stateNxt = dacsm_pkg::ST_MUTED;
                    end else begin
                        gainNxt = gain_r - 13'h0001;
                    end
                end
            end
            dacsm_pkg::ST_MUTED: begin
                gainNxt = '0;
                if (!muteReq) begin
                    stateNxt = dacsm_pkg::ST_RAMP_UP;
                end
            end
            dacsm_pkg::ST_RAMP_UP: begin
                if (muteReq) begin
                    stateNxt = dacsm_pkg::ST_RAMP_DOWN;
                end else if (frameRise) begin
                    if (gain_r + 13'h0001 >= rampLen) begin
                        gainNxt = rampLen;
                        stateNxt = dacsm_pkg::ST_PLAY;
                    end else begin
                        gainNxt = gain_r + 13'h0001;
                    end
                end
            end
            default: begin
                stateNxt = dacsm_pkg::ST_MUTED;
                gainNxt = '0;
            end
        endcase
        if (powerDown) begin
            stateNxt = dacsm_pkg::ST_MUTED;
            gainNxt = '0;
        end
    end

    // indicator low until a good ratio is seen, in power-down and when fully
    // muted; using the next state lets a mute release show in the same cycle
    wire indicatorNxt = !powerDown && ratioOkNxt
        && stateNxt != dacsm_pkg::ST_MUTED;
    logic indicator_r;
    logic [12:0] gainDen_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= dacsm_pkg::ST_MUTED;
            gain_r <= '0;
            gainDen_r <= LEN_S;
            indicator_r <= 1'b0;
        end else begin
            state_r <= stateNxt;
            gain_r <= gainNxt;
            gainDen_r <= rampLen;
            indicator_r <= indicatorNxt;
        end
    end

    // pair capture: words hold a whole slot, far beyond the sync delay
    logic [dacsm_pkg::SAMPLE_W-1:0] left_r, right_r;
    logic strobe_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mclkPrev_r <= 1'b0;
            framePrev_r <= 1'b0;
            togglePrev_r <= 1'b0;
            left_r <= '0;
            right_r <= '0;
            strobe_r <= 1'b0;
        end else begin
            mclkPrev_r <= mclkS;
            framePrev_r <= frameS;
            togglePrev_r <= toggleS;
            strobe_r <= pairArrived && !powerDown;
            if (pairArrived) begin
                left_r <= rxLeft;
                right_r <= rxRight;
            end
        end
    end

    // control port pin sharing; chip select is pin e, data in pin d,
    // control clock pin c, data out pin a
    logic spiMode_r, dataOut_r, dataOe_r;
    logic [1:0] addrBits_r;
    logic [7:0] spiShift_r;
    wire chipSelN = pinES;
    wire controlDataIn = pinDS;
    wire controlBitClock = pinCS;
    wire csFall = csPrev_r & ~chipSelN;
    wire cclkRise = controlBitClock & ~cclkPrev_r;
    wire cclkFall = ~controlBitClock & cclkPrev_r;
    wire spiSel = spiMode_r & ~chipSelN;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || powerDown) begin
            spiMode_r <= 1'b0;
            csPrev_r <= 1'b1;
            cclkPrev_r <= 1'b0;
            addrBits_r <= 2'h0;
            spiShift_r <= 8'h00;
            dataOut_r <= 1'b0;
            dataOe_r <= 1'b0;
        end else begin
            csPrev_r <= chipSelN;
            cclkPrev_r <= controlBitClock;
            if (ctrlMode && csFall) begin
                spiMode_r <= 1'b1;
            end
            addrBits_r <= (ctrlMode && !spiMode_r) ? {controlDataIn, chipSelN} : 2'h0;
            if (ctrlMode && spiSel && cclkRise) begin
                spiShift_r <= {spiShift_r[6:0], controlDataIn};
            end
            if (ctrlMode && spiSel && cclkFall) begin
                dataOut_r <= ctrlDataOutBit;
            end
            dataOe_r <= ctrlMode && spiSel;
        end
    end

    assign modePinAOut = dataOut_r;
    assign modePinAOe = dataOe_r;
    assign sampleLeft = left_r;
    assign sampleRight = right_r;
    assign sampleStrobe = strobe_r;
    assign gainNum = gain_r;
    assign gainDen = gainDen_r;
    assign speedMode = speed_r;
    assign audioFormat = format_r;
    assign deemphSelect = deemph_r;
    assign lowPower = lowPower_r;
    assign ratioFault = ~ratioOk_r;
    assign spiModeActive = spiMode_r;
    assign chipAddrBits = addrBits_r;
    assign spiShiftData = spiShift_r;
    assign muteIndicatorOut = indicator_r;
endmodule : dacsm_top

// file: src/dacsm_pkg.sv
// constants and types shared by the converter front end
// assumes a 250 MHz system clock and a free running serial bit clock
package dacsm_pkg;
    localparam int SAMPLE_W = 24;
    localparam int SLOT_W = 32;
    localparam int SLOT_CNT_W = 6;
    localparam int RAMP_W = 13;
    localparam int MCLK_CNT_W = 11;
    localparam int SYNC_W = 11;

    // serial formats, low two mode bits
    localparam logic [1:0] FMT_LEFT_JUST = 2'h0;
    localparam logic [1:0] FMT_I2S = 2'h1;
    localparam logic [1:0] FMT_RIGHT16 = 2'h2;
    localparam logic [1:0] FMT_RIGHT24 = 2'h3;

    // de-emphasis choices, mode bits 3:2 in single speed
    localparam logic [1:0] DEEMPH_32K = 2'h0;
    localparam logic [1:0] DEEMPH_44K1 = 2'h1;
    localparam logic [1:0] DEEMPH_48K = 2'h2;
    localparam logic [1:0] DEEMPH_OFF = 2'h3;

    // mode bit positions
    localparam int MODE_HI_BIT = 4;
    localparam int MODE_MID_BIT = 3;
    localparam int MODE_DQ_BIT = 2;

    // ramp lengths in frame clocks per speed mode
    localparam int RAMP_SINGLE = 1152;
    localparam int RAMP_DOUBLE = 2304;
    localparam int RAMP_QUAD = 4608;

    // allowed master clock ratios in single speed; halved per speed step
    localparam logic [MCLK_CNT_W-1:0] RATIO_A = 11'h100;
    localparam logic [MCLK_CNT_W-1:0] RATIO_B = 11'h180;
    localparam logic [MCLK_CNT_W-1:0] RATIO_C = 11'h200;
    localparam logic [MCLK_CNT_W-1:0] RATIO_D = 11'h300;
    localparam logic [MCLK_CNT_W-1:0] RATIO_TOL = 11'h001;

    typedef enum logic [1:0] {SPEED_SINGLE, SPEED_DOUBLE, SPEED_QUAD} dacsm_speed_type;
    typedef enum logic [1:0] {ST_PLAY, ST_RAMP_DOWN, ST_MUTED, ST_RAMP_UP} dacsm_state_type;
endpackage : dacsm_pkg

// file: src/dacsm_pin_sync.sv
// three flop synchroniser for a vector of asynchronous inputs
// assumes each bit is a slow level or a clock well below half of clk
`timescale 1ns/1ps
module dacsm_pin_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] st2_r;
    logic [W-1:0] st3_r;
    logic [W-1:0] q_r;
    wire [W-1:0] agree = ~(st2_r ^ st3_r);

    // a bit changes only once the second and third stage agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            st2_r <= '0;
            st3_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            st2_r <= meta_r;
            st3_r <= st2_r;
            q_r <= (agree & st3_r) | (~agree & q_r);
        end
    end

    assign q = q_r;
endmodule : dacsm_pin_sync

// file: src/dacsm_serial_rx.sv
// serial audio receiver on the bit clock; publishes left/right pairs
// assumes frame and data change away from the rising bit clock
`timescale 1ns/1ps
module dacsm_serial_rx (
    input wire logic audioBitClock,
    input wire logic rst_n,
    input wire logic [1:0] fmtSys,
    input wire logic audioFrameClock,
    input wire logic audioSerialIn,
    output logic [dacsm_pkg::SAMPLE_W-1:0] pairLeft,
    output logic [dacsm_pkg::SAMPLE_W-1:0] pairRight,
    output logic pairToggle
);
    logic rstMeta_r, rstLink_r;
    logic [1:0] fmtMeta_r, fmt_r;
    logic prevFrame_r, haveLeft_r, pairToggle_r;
    logic [dacsm_pkg::SLOT_W-1:0] shift_r;
    logic [dacsm_pkg::SLOT_CNT_W-1:0] slotCnt_r;
    logic [dacsm_pkg::SAMPLE_W-1:0] leftHold_r, pairLeft_r, pairRight_r;

    // msb-aligned pick of the first bits of a slot, zero padded
    function automatic logic [dacsm_pkg::SAMPLE_W-1:0] justifyWord(
        input logic [dacsm_pkg::SLOT_W-1:0] sh, input logic [5:0] n);
        logic [dacsm_pkg::SLOT_W-1:0] t;
        t = (n >= 6'd24) ? (sh >> (n - 6'd24)) : (sh << (6'd24 - n));
        return t[dacsm_pkg::SAMPLE_W-1:0];
    endfunction : justifyWord

    wire rightJust = fmt_r[1];
    wire frameEdge = audioFrameClock != prevFrame_r;
    wire isI2s = fmt_r == dacsm_pkg::FMT_I2S;
    // i2s msb comes one bit clock after the frame edge, so drop the first bit
    wire [5:0] slotBits = (isI2s && slotCnt_r != 6'h00) ? slotCnt_r - 6'h01 : slotCnt_r;
    // left formats freeze once the slot is full
    wire shiftEn = rightJust || (slotCnt_r < 6'(dacsm_pkg::SLOT_W));
    wire [dacsm_pkg::SAMPLE_W-1:0] word = (fmt_r == dacsm_pkg::FMT_RIGHT24) ? shift_r[23:0]
        : (fmt_r == dacsm_pkg::FMT_RIGHT16) ? {shift_r[15:0], 8'h00}
        : justifyWord(shift_r, slotBits);
    // the level before the edge names the finished channel; i2s left is low
    wire leftDone = isI2s ? ~prevFrame_r : prevFrame_r;

    // reset and format are quasi static levels, two flops each
    always_ff @(posedge audioBitClock) begin
        rstMeta_r <= rst_n;
        rstLink_r <= rstMeta_r;
        fmtMeta_r <= fmtSys;
        fmt_r <= fmtMeta_r;
    end

    // msb first shift-in on the rising bit clock
    always_ff @(posedge audioBitClock) begin
        if (!rstLink_r) begin
            prevFrame_r <= 1'b0;
            shift_r <= '0;
            slotCnt_r <= '0;
        end else begin
            prevFrame_r <= audioFrameClock;
            if (frameEdge) begin
                shift_r <= {{(dacsm_pkg::SLOT_W-1){1'b0}}, audioSerialIn};
                slotCnt_r <= 6'h01;
            end else if (shiftEn) begin
                shift_r <= {shift_r[dacsm_pkg::SLOT_W-2:0], audioSerialIn};
                slotCnt_r <= slotCnt_r + 6'h01;
            end
        end
    end

    // a left word waits for its right partner, then both leave together
    always_ff @(posedge audioBitClock) begin
        if (!rstLink_r) begin
            haveLeft_r <= 1'b0;
            leftHold_r <= '0;
            pairLeft_r <= '0;
            pairRight_r <= '0;
            pairToggle_r <= 1'b0;
        end else if (frameEdge) begin
            if (leftDone) begin
                leftHold_r <= word;
                haveLeft_r <= 1'b1;
            end else if (haveLeft_r) begin
                pairLeft_r <= leftHold_r;
                pairRight_r <= word;
                pairToggle_r <= ~pairToggle_r;
                haveLeft_r <= 1'b0;
            end
        end
    end

    assign pairLeft = pairLeft_r;
    assign pairRight = pairRight_r;
    assign pairToggle = pairToggle_r;
endmodule : dacsm_serial_rx

// file: testbench/dacsm_top_props.sv
// port assertions for the converter front end
// bound onto dacsm_top; all ports in the clk_sys domain
`timescale 1ns/1ps
module dacsm_top_props #(
    parameter int RAMP_SINGLE = 1152,
    parameter int RAMP_DOUBLE = 2304,
    parameter int RAMP_QUAD = 4608
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ctrlPowerDown,
    input wire logic sampleStrobe,
    input wire logic [dacsm_pkg::RAMP_W-1:0] gainNum,
    input wire logic [dacsm_pkg::RAMP_W-1:0] gainDen,
    input wire logic [1:0] speedMode,
    input wire logic lowPower,
    input wire logic ratioFault,
    input wire logic spiModeActive,
    input wire logic [1:0] chipAddrBits,
    input wire logic muteIndicatorOut
);
    logic [12:0] denExp;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ramp length each speed should report
    assign denExp = (speedMode == 2'h0) ? 13'(RAMP_SINGLE) :
        (speedMode == 2'h1) ? 13'(RAMP_DOUBLE) : 13'(RAMP_QUAD);
    a_reset_clears: assert property (disable iff (1'b0)
        !rst_n |=> lowPower && !muteIndicatorOut && !spiModeActive && !sampleStrobe)
        else $error("outputs not reset");
    a_mute_after_ramp: assert property (
        $fell(muteIndicatorOut) |-> gainNum == 13'h0000 || lowPower || ratioFault)
        else $error("indicator fell early");
    a_ind_needs_ok: assert property (
        muteIndicatorOut |-> !lowPower && !ratioFault)
        else $error("indicator high in fault");
    // steps judged only under a settled length
    a_gain_step: assert property (
        $stable(gainDen) [*2] ##0 $changed(gainNum) |-> lowPower ||
        gainNum == $past(gainNum) + 13'h0001 || gainNum == $past(gainNum) - 13'h0001)
        else $error("gain jumped");
    a_ramp_paced: assert property (
        $changed(gainNum) && !lowPower |=> $stable(gainNum) [*8])
        else $error("gain stepped too fast");
    a_den_speed: assert property (
        $stable(speedMode) [*4] |-> gainDen == denExp)
        else $error("wrong ramp length");
    a_spi_sticky: assert property (
        spiModeActive && !ctrlPowerDown |=> spiModeActive)
        else $error("spi mode dropped");
    a_spi_addr_zero: assert property (
        spiModeActive && $past(spiModeActive) |-> chipAddrBits == 2'h0)
        else $error("address bits in spi mode");
    a_strobe_pulse: assert property (
        sampleStrobe |=> !sampleStrobe)
        else $error("strobe too long");
    c_muted: cover property ($fell(muteIndicatorOut));
    c_spi: cover property ($rose(spiModeActive));
    c_pair: cover property (sampleStrobe);
endmodule : dacsm_top_props

bind dacsm_top dacsm_top_props #(.RAMP_SINGLE(RAMP_SINGLE), .RAMP_DOUBLE(RAMP_DOUBLE),
    .RAMP_QUAD(RAMP_QUAD)) u_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .ctrlPowerDown(ctrlPowerDown), .sampleStrobe(sampleStrobe), .gainNum(gainNum),
    .gainDen(gainDen), .speedMode(speedMode), .lowPower(lowPower), .ratioFault(ratioFault),
    .spiModeActive(spiModeActive), .chipAddrBits(chipAddrBits),
    .muteIndicatorOut(muteIndicatorOut));

// file: testbench/dacsm_audio_src.sv
// serial audio source model: clocks and data
// assumes double speed, left justified, 32 bit slots, 256 fs
`timescale 1ns/1ps
module dacsm_audio_src (
    output logic bitClock,
    output logic frameClock,
    output logic serialData,
    output logic masterClock,
    input wire logic [23:0] leftWord,
    input wire logic [23:0] rightWord
);
    logic [5:0] bitPos = 6'h3f;
    logic [23:0] leftHold = 24'h000000;
    logic [23:0] rightHold = 24'h000000;
    logic [23:0] word;
    // 64 bit clocks of 160 ns: about 98 kHz, double speed
    initial begin
        bitClock = 1'b0;
        #7;
        forever #80 bitClock = ~bitClock;
    end
    initial begin
        masterClock = 1'b0;
        forever #20 masterClock = ~masterClock;
    end
    // frame high is left; pads are the inverted lsb
    assign frameClock = ~bitPos[5];
    assign word = frameClock ? leftHold : rightHold;
    assign serialData = (bitPos[4:0] < 5'h18) ? word[5'h17 - bitPos[4:0]] : ~word[0];
    // words latch at frame start, never split
    always @(negedge bitClock) begin
        bitPos <= bitPos + 6'h01;
        if (bitPos == 6'h3f) begin
            leftHold <= leftWord;
            rightHold <= rightWord;
        end
    end
endmodule : dacsm_audio_src

// file: testbench/dacsm_top_bench.sv
// bench for the front end: modes, samples, mute ramp, spi entry, bad ratio
// uses dacsm_audio_src and short ramp lengths
`timescale 1ns/1ps
module dacsm_top_bench;
    localparam int RD = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic bck, frm, sdi, mclk, smn, ifs, pE, pD, pC, pB, pA, aOut, aOe, pd, dob, stb;
    logic lowP, rFlt, spi, mInd;
    logic [4:0] cBits, m;
    logic [23:0] lW, rW, sL, sR;
    logic [12:0] gN, gD;
    logic [1:0] spd, fmt, dem, adr;
    logic [7:0] audio_serial_in, eByte = 8'h00;
    logic [31:0] seed = 32'h00014cff;
    int err_count = 0, checks = 0, cycles = 0, i;
    dacsm_top #(.RAMP_SINGLE(6), .RAMP_DOUBLE(RD), .RAMP_QUAD(8)) dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .audioBitClock(bck), .audioFrameClock(frm), .audioSerialIn(sdi),
        .masterClock(mclk), .softMuteN(smn), .interfaceSelect(ifs), .modePinE(pE),
        .modePinD(pD), .modePinC(pC), .modePinB(pB), .modePinAIn(pA), .modePinAOut(aOut),
        .modePinAOe(aOe), .ctrlModeBits(cBits), .ctrlPowerDown(pd), .ctrlDataOutBit(dob),
        .sampleLeft(sL), .sampleRight(sR), .sampleStrobe(stb), .gainNum(gN), .gainDen(gD),
        .speedMode(spd), .audioFormat(fmt), .deemphSelect(dem), .lowPower(lowP),
        .ratioFault(rFlt), .spiModeActive(spi), .chipAddrBits(adr), .spiShiftData(audio_serial_in),
        .muteIndicatorOut(mInd));
    dacsm_audio_src src (.bitClock(bck), .frameClock(frm), .serialData(sdi),
        .masterClock(mclk), .leftWord(lW), .rightWord(rW));
    initial forever #2 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [1:0] eSpd(input logic [4:0] b);
        return (b[4] & b[3]) ? (b[2] ? 2'h1 : 2'h2) : 2'h0;
    endfunction : eSpd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("mismatches %0d of %0d compares", err_count, checks);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // drive at rising edges, look at settled falling edges
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic look(input int n = 0);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : look
    task automatic waitStrobe();
        for (i = 0; i == 0 || (stb !== 1'b1 && i < 6000); i++) look();
    endtask : waitStrobe
    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        {smn, ifs, pd, dob, cBits, lW, rW} = {4'h8, 5'h00, 48'h0};
        {pE, pD, pC, pB, pA} = 5'h1c;
        look(130);
        check({lowP, rFlt, mInd, spi}, 4'hc);
        cyc(1);
        rst_n <= 1'b1;
        // corner then random codes; odd passes in control mode
        for (int k = 0; k < 8; k++) begin
            m = k == 0 ? 5'h1d : k == 1 ? 5'h1a : k == 2 ? 5'h13 : 5'(xs());
            cyc(1);
            ifs <= k[0];
            cBits <= m;
            cyc(8);
            {pE, pD, pC, pB, pA} <= k[0] ? {1'b1, ~m[3:0]} : m;
            look(8);
            check({spd, fmt}, {eSpd(m), m[1:0]});
            check(dem, m[4] ? 2'h3 : m[3:2]);
            check({spi, adr}, k[0] ? {1'b0, ~m[3], 1'b1} : 3'h0);
        end
        cyc(1);
        ifs <= 1'b0;
        cyc(8);
        {pE, pD, pC, pB, pA} <= 5'h1c;
        for (int k = 0; k < 3; k++) begin
            cyc(1);
            lW <= k == 0 ? 24'h800000 : 24'(xs());
            rW <= k == 0 ? 24'h7fffff : 24'(xs());
            repeat (2) waitStrobe();
            check({sL, rW}, {lW, sR});
        end
        check({rFlt, mInd}, 2'h1);
        for (i = 0; gN !== 13'(RD) && i < 30000; i++) look();
        check(gD, RD);
        // mute ramp: RD frames of 2560 cycles, indicator at its end
        cyc(1);
        smn <= 1'b0;
        for (i = 0; mInd !== 1'b0 && i < 30000; i++) look();
        check({gN, i > 2560 * (RD - 1) - 50, i < 2560 * RD + 50}, 15'h3);
        cyc(1);
        smn <= 1'b1;
        look(8);
        check({mInd, gN < 13'h0002}, 2'h3);
        for (i = 0; gN !== 13'(RD) && i < 30000; i++) look();
        check(i > 2560 * (RD - 2), 1'b1);
        cyc(1);
        {ifs, pC} <= 2'h2;
        cyc(8);
        pE <= 1'b0;
        look(8);
        check(spi, 1'b1);
        for (int k = 0; k < 8; k++) begin
            m = 5'(xs());
            cyc(1);
            {pD, dob} <= m[1:0];
            eByte = {eByte[6:0], m[1]};
            cyc(8);
            pC <= 1'b1;
            cyc(8);
            pC <= 1'b0;
            look(8);
            check({aOe, aOut}, {1'b1, m[0]});
        end
        check(audio_serial_in, eByte);
        cyc(1);
        pE <= 1'b1;
        look(8);
        check(spi, 1'b1);
        cyc(1);
        pd <= 1'b1;
        look(8);
        check({lowP, spi, mInd, gN}, 16'h8000);
        // 256 fs is not a quad speed ratio
        cyc(1);
        {pd, ifs} <= 2'h0;
        {pE, pD, pC, pB, pA} <= 5'h18;
        look(8000);
        check({rFlt, mInd}, 2'h2);
        finish_test();
    end
endmodule : dacsm_top_bench
